// *** verilog/irq_and_watchdog_unit.sv ***
// Interrupt controller and watchdog with an APB register slave
`include "irq_consts.svh"
`default_nettype none
// Behaviour
// R1 - Eight hardware event sources are recognised
// R2 - Trap vectors to 0x001, clears global enable
// R3 - Enable/disable instructions set/clear global enable
// R4 - Return sets global enable and resumes
// R5 - Event flags stick until software writes zero
// R6 - Flag reads only while its enable set
// R7 - Enabled pending flag vectors to 0x008
// R8 - Handler must not enable just before return
// R9 - Timer0 overflow sets its flag
// R10 - Timer1 underflow sets its flag
// R11 - Timer3 underflow sets its flag
// R12 - Enabled input pin changes set shared flag
// R13 - Edge select suppresses change on PB0/PB1
// R14 - Watchdog exists by config, runs by bit
// R15 - Watchdog counts its own free oscillator
// R16 - Expiry resets or interrupts, clears timeout bit
// R17 - Base period 3.5, 15, 60, 250 ms
// R18 - Prescaler ratio depends on expiry mode
// R19 - Kick clears counters and sets timeout bit
// R20 - Interrupt-mode expiry sets flag bit six
// R21 - Selected edge on PB0/PB1 sets flags
// R22 - Low-voltage falling output sets its flag
// R23 - Event wins over simultaneous software clear
// R24 - Several pending flags share one interrupt
module irq_and_watchdog_unit #(
  // Base watchdog periods in oscillator ticks
  parameter int unsigned WDT_CNT_0 = `WDT_T0_US * `WDT_OSC_KHZ / 1000,
  parameter int unsigned WDT_CNT_1 = `WDT_T1_US * `WDT_OSC_KHZ / 1000,
  parameter int unsigned WDT_CNT_2 = `WDT_T2_US * `WDT_OSC_KHZ / 1000,
  parameter int unsigned WDT_CNT_3 = `WDT_T3_US * `WDT_OSC_KHZ / 1000
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Instruction strobes from the core decoder
  input  wire logic        op_trap,
  input  wire logic        irq_on_instruction,
  input  wire logic        irq_off_instruction,
  input  wire logic        return_from_irq_instruction,
  input  wire logic        kick_watchdog_instruction,
  // Fetch redirection to the core
  output logic             fetch_redirect,
  output logic [11:0]      fetch_vector,
  output logic             global_irq_enable,
  // Configuration words
  input  wire logic        cfg_watchdog_exists,
  input  wire logic        cfg_watchdog_irq_mode,
  input  wire logic [1:0]  cfg_watchdog_period,
  // Timer events from same-clock logic
  input  wire logic        timer0_overflow,
  input  wire logic        timer1_underflow,
  input  wire logic        timer3_underflow,
  // Asynchronous pins
  input  wire logic [7:0]  porta_in,
  input  wire logic [5:0]  portb_in,
  input  wire logic [13:0] pin_is_input,
  input  wire logic        low_voltage_out,
  input  wire logic        watchdog_osc,
  // Watchdog reset request
  output logic             watchdog_reset_req
);

  // ========
  // Register state
  logic [7:0] event_flag_reg;      // Sticky event flags
  logic [7:0] event_enable_reg;    // Per-source enables
  logic       watchdog_run_enable; // Power control run bit
  logic       watchdog_expired_n;  // Timeout status, low on expiry
  logic [7:0] porta_wake_enable;   // Port A change enables
  logic [5:0] portb_wake_enable;   // Port B change enables
  logic       ext_edge0_select;    // PB0 edge mode
  logic       ext_edge1_select;    // PB1 edge mode
  logic       ext_edge_polarity;   // 1 rising, 0 falling
  logic       prescaler0_to_watchdog;      // Prescaler owner
  logic [2:0] prescaler0_ratio_select;     // Prescaler ratio
  irq_pkg::service_state_t state_r;        // Service state
  irq_pkg::service_state_t state_nxt;      // Next service state

  // ========
  // Event wires from submodules, and the selected watchdog period
  logic        change_ev;   // Pin change pulse
  logic        ext0_ev;     // PB0 edge pulse
  logic        ext1_ev;     // PB1 edge pulse
  logic        low_volt_ev; // Detector fall pulse
  logic        wdt_expire;  // Watchdog expiry pulse
  logic [19:0] base_limit;  // Selected base period

  // ========
  // APB decode
  wire setup_ph = psel & ~penable;                   // Setup phase
  wire wr_en    = psel & penable & pready & pwrite; // Write commits
  wire hit_flag   = (paddr == `REG_FLAG);
  wire hit_enable = (paddr == `REG_ENABLE);
  wire hit_power  = (paddr == `REG_POWER);
  wire hit_status = (paddr == `REG_STATUS);
  wire hit_wake_a = (paddr == `REG_WAKE_A);
  wire hit_wake_b = (paddr == `REG_WAKE_B);
  wire hit_ext    = (paddr == `REG_EXT);
  wire hit_wdt    = (paddr == `REG_WDT);
  wire hit_core   = (paddr == `REG_CORE);
  // Any mapped offset
  wire hit_any = hit_flag | hit_enable | hit_power | hit_status | hit_wake_a
                 | hit_wake_b | hit_ext | hit_wdt | hit_core;

  // ========
  // Event collection
  wire wdt_run      = cfg_watchdog_exists & watchdog_run_enable; // see R14
  wire wdt_irq_ev   = wdt_expire & cfg_watchdog_irq_mode;        // see R20
  wire wdt_reset_ev = wdt_expire & ~cfg_watchdog_irq_mode;       // see R16
  // One bit per hardware source
  logic [7:0] hw_ev;
  assign hw_ev[`EV_TIMER0]     = timer0_overflow;  // see R9
  assign hw_ev[`EV_TIMER1]     = timer1_underflow; // see R10
  assign hw_ev[`EV_TIMER3]     = timer3_underflow; // see R11
  assign hw_ev[`EV_PIN_CHANGE] = change_ev;        // see R12
  assign hw_ev[`EV_EXT0]       = ext0_ev;          // see R21
  assign hw_ev[`EV_EXT1]       = ext1_ev;          // see R21
  assign hw_ev[`EV_WATCHDOG]   = wdt_irq_ev;       // see R20
  assign hw_ev[`EV_LOW_VOLT]   = low_volt_ev;      // see R22

  // ========
  // Flag update: writing 0 clears, event wins
  wire [7:0] flag_clr = (wr_en & hit_flag) ? ~pwdata[7:0] : 8'h00;           // see R5
  wire [7:0] flag_nxt = (event_flag_reg & ~flag_clr) | hw_ev;                // see R1 R23

  // ========
  // Interrupt decision
  wire [7:0] armed      = event_flag_reg & event_enable_reg;
  wire       hw_pending = |armed;                                            // see R24
  wire       take_trap  = op_trap;                                           // see R2
  wire       take_hw    = ~op_trap & global_irq_enable & hw_pending;         // see R7
  // Global enable next value
  wire       gie_nxt = (take_trap | take_hw) ? 1'b0 :                        // see R2 R7
                       (return_from_irq_instruction | irq_on_instruction) ? 1'b1 : // see R3 R4
                       irq_off_instruction ? 1'b0 :                          // see R3
                       global_irq_enable;

  // ========
  // Watchdog period select
  assign base_limit = (cfg_watchdog_period == 2'h0) ? 20'(WDT_CNT_0) :
                      (cfg_watchdog_period == 2'h1) ? 20'(WDT_CNT_1) :
                      (cfg_watchdog_period == 2'h2) ? 20'(WDT_CNT_2) :
                      20'(WDT_CNT_3); // see R17

  // ========
  // Read data mux
  wire [31:0] rd_data =
    hit_flag   ? {24'h000000, armed} :                                       // see R6
    hit_enable ? {24'h000000, event_enable_reg} :
    hit_power  ? {24'h000000, watchdog_run_enable, 7'h00} :
    hit_status ? {24'h000000, 3'h0, watchdog_expired_n, 4'h0} :
    hit_wake_a ? {24'h000000, porta_wake_enable} :
    hit_wake_b ? {26'h0000000, portb_wake_enable} :
    hit_ext    ? {29'h00000000, ext_edge_polarity, ext_edge1_select, ext_edge0_select} :
    hit_wdt    ? {28'h0000000, prescaler0_to_watchdog, prescaler0_ratio_select} :
    hit_core   ? {29'h00000000, 2'(state_r), global_irq_enable} :
    32'h00000000;

  // ========
  // Service state sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      irq_pkg::SVC_IDLE: begin
        if (take_trap) begin
          state_nxt = irq_pkg::SVC_TRAP;
        end else if (take_hw) begin
          state_nxt = irq_pkg::SVC_HW;
        end
      end
      irq_pkg::SVC_TRAP, irq_pkg::SVC_HW: begin
        // Return ends service; nested entries restart it
        if (take_trap) begin
          state_nxt = irq_pkg::SVC_TRAP;
        end else if (take_hw) begin
          state_nxt = irq_pkg::SVC_HW;
        end else if (return_from_irq_instruction) begin
          state_nxt = irq_pkg::SVC_IDLE; // see R4
        end
      end
      default: begin
        state_nxt = irq_pkg::SVC_IDLE;
      end
    endcase
  end

  // ========
  // APB answer registers, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      if (setup_ph) begin
        prdata  <= pwrite ? 32'h00000000 : rd_data;
        pslverr <= ~hit_any;
      end
    end
  end

  // ========
  // Event flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flag_reg <= 8'h00;
    end else begin
      event_flag_reg <= flag_nxt; // see R5 R23
    end
  end

  // ========
  // Software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_enable_reg        <= 8'h00;
      watchdog_run_enable     <= `PWR_RUN_RST;
      porta_wake_enable       <= 8'h00;
      portb_wake_enable       <= 6'h00;
      ext_edge0_select        <= 1'b0;
      ext_edge1_select        <= 1'b0;
      ext_edge_polarity       <= 1'b0;
      prescaler0_to_watchdog  <= 1'b0;
      prescaler0_ratio_select <= 3'h0;
    end else if (wr_en) begin
      if (hit_enable) begin
        event_enable_reg <= pwdata[7:0];
      end
      if (hit_power) begin
        watchdog_run_enable <= pwdata[`PWR_RUN_BIT]; // see R14
      end
      if (hit_wake_a) begin
        porta_wake_enable <= pwdata[7:0];
      end
      if (hit_wake_b) begin
        portb_wake_enable <= pwdata[5:0];
      end
      if (hit_ext) begin
        ext_edge0_select  <= pwdata[0];
        ext_edge1_select  <= pwdata[1];
        ext_edge_polarity <= pwdata[2];
      end
      if (hit_wdt) begin
        prescaler0_to_watchdog  <= pwdata[3]; // see R18
        prescaler0_ratio_select <= pwdata[2:0];
      end
    end
  end

  // ========
  // Timeout status: expiry beats kick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_expired_n <= `EXP_N_RST;
    end else if (wdt_expire) begin
      watchdog_expired_n <= 1'b0; // see R16
    end else if (kick_watchdog_instruction) begin
      watchdog_expired_n <= 1'b1; // see R19
    end
  end

  // ========
  // Global enable, service state, fetch outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable  <= 1'b0;
      state_r            <= irq_pkg::SVC_IDLE;
      fetch_redirect     <= 1'b0;
      fetch_vector       <= 12'h000;
      watchdog_reset_req <= 1'b0;
    end else begin
      global_irq_enable  <= gie_nxt;
      state_r            <= state_nxt;
      fetch_redirect     <= take_trap | take_hw;
      watchdog_reset_req <= wdt_reset_ev; // see R16
      if (take_trap) begin
        fetch_vector <= `VEC_TRAP; // see R2
      end else if (take_hw) begin
        fetch_vector <= `VEC_HW; // see R7
      end
    end
  end

  // ========
  // Pin synchronisers and change detection
  pin_change_detect u_pins (
    .pclk        (pclk),
    .presetn     (presetn),
    .pins_in     ({low_voltage_out, portb_in, porta_in}),
    .wake_en     ({portb_wake_enable, porta_wake_enable}),
    .is_input    (pin_is_input),
    .edge_sel    ({ext_edge1_select, ext_edge0_select}),
    .polarity    (ext_edge_polarity),
    .change_ev   (change_ev),
    .ext0_ev     (ext0_ev),
    .ext1_ev     (ext1_ev),
    .low_volt_ev (low_volt_ev)
  );

  // ========
  // Watchdog counter
  watchdog_timer u_wdt (
    .pclk         (pclk),
    .presetn      (presetn),
    .osc          (watchdog_osc),
    .run          (wdt_run),
    .irq_mode     (cfg_watchdog_irq_mode),
    .base_limit   (base_limit),
    .to_prescaler (prescaler0_to_watchdog),
    .ratio_sel    (prescaler0_ratio_select),
    .kick         (kick_watchdog_instruction),
    .expire       (wdt_expire)
  );

endmodule
`default_nettype wire

// *** verilog/irq_consts.svh ***
// Constants for the interrupt and watchdog unit
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH
// ========
// Fetch vectors
`define VEC_W          12
`define VEC_TRAP       12'h001
`define VEC_HW         12'h008
// ========
// Register byte offsets
`define REG_FLAG       8'h00
`define REG_ENABLE     8'h04
`define REG_POWER      8'h08
`define REG_STATUS     8'h0C
`define REG_WAKE_A     8'h10
`define REG_WAKE_B     8'h14
`define REG_EXT        8'h18
`define REG_WDT        8'h1C
`define REG_CORE       8'h20
// ========
// Event bit positions in flag and enable
`define EV_TIMER0      0
`define EV_TIMER1      1
`define EV_TIMER3      2
`define EV_PIN_CHANGE  3
`define EV_EXT0        4
`define EV_EXT1        5
`define EV_WATCHDOG    6
`define EV_LOW_VOLT    7
// ========
// Field positions and reset values
`define PWR_RUN_BIT    7
`define STAT_EXP_BIT   4
`define PWR_RUN_RST    1'b1
`define EXP_N_RST      1'b1
// ========
// Watchdog base periods in microseconds
`define WDT_T0_US      3500
`define WDT_T1_US      15000
`define WDT_T2_US      60000
`define WDT_T3_US      250000
`define WDT_OSC_KHZ    32
`endif

// *** verilog/irq_pkg.sv ***
// Types shared by the interrupt and watchdog unit
`default_nettype none
package irq_pkg;
  // Service state of the interrupt sequencer
  typedef enum logic [1:0] {
    SVC_IDLE,
    SVC_TRAP,
    SVC_HW
  } service_state_t;
endpackage
`default_nettype wire

// *** verilog/pin_change_detect.sv ***
// Pin synchroniser with level-change, edge and low-voltage detection
`default_nettype none
module pin_change_detect (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Pins: 7:0 port A, 13:8 port B, 14 detector
  input  wire logic [14:0] pins_in,
  input  wire logic [13:0] wake_en,
  input  wire logic [13:0] is_input,
  input  wire logic [1:0]  edge_sel,
  input  wire logic        polarity,
  // Event pulses
  output logic             change_ev,
  output logic             ext0_ev,
  output logic             ext1_ev,
  output logic             low_volt_ev
);
  // ========
  // Synchroniser and history
  logic [14:0] s1_r;   // First stage, read by s2 only
  logic [14:0] s2_r;   // Second stage
  logic [14:0] prev_r; // Previous settled level
  logic [1:0]  prime_r; // Waits out the chain fill
  logic [13:0] qual;   // Qualified changes
  wire         primed = (prime_r == 2'h3);
  wire  [14:0] rise   = s2_r & ~prev_r;
  wire  [14:0] fall   = ~s2_r & prev_r;
  // Per-pin change qualification
  genvar i;
  generate
    for (i = 0; i < 14; i++) begin : g_pin
      if (i == 8 || i == 9) begin : g_shared
        // Edge mode steals the pin from change detection
        assign qual[i] = (s2_r[i] ^ prev_r[i]) & wake_en[i] & is_input[i]
                         & ~edge_sel[i-8]; // see R13
      end else begin : g_plain
        assign qual[i] = (s2_r[i] ^ prev_r[i]) & wake_en[i] & is_input[i];
      end
    end
  endgenerate
  // Synchroniser, history and event registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r        <= 15'h0000;
      s2_r        <= 15'h0000;
      prev_r      <= 15'h0000;
      prime_r     <= 2'h0;
      change_ev   <= 1'b0;
      ext0_ev     <= 1'b0;
      ext1_ev     <= 1'b0;
      low_volt_ev <= 1'b0;
    end else begin
      s1_r        <= pins_in;
      s2_r        <= s1_r;
      prev_r      <= s2_r;
      prime_r     <= primed ? prime_r : prime_r + 2'h1;
      change_ev   <= primed & (|qual); // see R12
      ext0_ev     <= primed & edge_sel[0] & (polarity ? rise[8] : fall[8]); // see R21
      ext1_ev     <= primed & edge_sel[1] & (polarity ? rise[9] : fall[9]); // see R21
      low_volt_ev <= primed & fall[14]; // see R22
    end
  end
endmodule
`default_nettype wire

// *** verilog/watchdog_timer.sv ***
// Watchdog counter and prescaler clocked by pclk, advanced by ticks of its own oscillator
`default_nettype none
module watchdog_timer (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Oscillator pin and control
  input  wire logic        osc,
  input  wire logic        run,
  input  wire logic        irq_mode,
  input  wire logic [19:0] base_limit,
  input  wire logic        to_prescaler,
  input  wire logic [2:0]  ratio_sel,
  input  wire logic        kick,
  // Expiry pulse
  output logic             expire
);
  // ========
  // Oscillator edge detection
  logic        osc1_r;     // First stage, read by osc2 only
  logic        osc2_r;
  logic        osc3_r;
  logic [19:0] base_cnt_r; // Oscillator ticks in base period
  logic [8:0]  pre_cnt_r;  // Base periods counted
  wire         tick  = osc2_r & ~osc3_r;
  // Ratio 1:1..1:128 for reset, 1:2..1:256 for interrupt
  wire  [8:0]  ratio = !to_prescaler ? 9'h001 :
                       irq_mode ? (9'h002 << ratio_sel) : (9'h001 << ratio_sel); // see R18
  wire         base_done = run & tick & (base_cnt_r == base_limit - 20'h00001); // see R17
  wire         pre_done  = base_done & (pre_cnt_r == ratio - 9'h001);
  // Counters advance only on oscillator ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc1_r     <= 1'b0;
      osc2_r     <= 1'b0;
      osc3_r     <= 1'b0;
      base_cnt_r <= 20'h00000;
      pre_cnt_r  <= 9'h000;
      expire     <= 1'b0;
    end else begin
      osc1_r <= osc;
      osc2_r <= osc1_r;
      osc3_r <= osc2_r; // see R15
      expire <= pre_done & ~kick;
      if (kick) begin
        base_cnt_r <= 20'h00000; // see R19
        if (to_prescaler) begin
          pre_cnt_r <= 9'h000; // see R19
        end
      end else if (run & tick) begin // see R14
        base_cnt_r <= base_done ? 20'h00000 : base_cnt_r + 20'h00001;
        if (base_done) begin
          pre_cnt_r <= pre_done ? 9'h000 : pre_cnt_r + 9'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/irq_unit_sva.sv ***
// Concurrent checks on the interrupt unit ports
`default_nettype none
module irq_unit_sva (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus handshake
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // Core strobes and redirect
  input wire logic        op_trap,
  input wire logic        irq_on_instruction,
  input wire logic        irq_off_instruction,
  input wire logic        return_from_irq_instruction,
  input wire logic        fetch_redirect,
  input wire logic [11:0] fetch_vector,
  input wire logic        global_irq_enable,
  // Watchdog mode
  input wire logic        cfg_watchdog_exists,
  input wire logic        cfg_watchdog_irq_mode,
  input wire logic        watchdog_reset_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Trap request and its answer
  sequence trap_req_s;
    op_trap;
  endsequence
  sequence trap_ans_s;
    fetch_redirect && fetch_vector == 12'h001 && !global_irq_enable;
  endsequence
  trap_vector_a: assert property (trap_req_s |=> trap_ans_s)
    else $error("trap did not redirect");
  gie_on_a: assert property (irq_on_instruction && !op_trap |=> global_irq_enable || fetch_redirect)
    else $error("enable instruction lost");
  gie_off_a: assert property (irq_off_instruction && !irq_on_instruction && !return_from_irq_instruction
    |=> !global_irq_enable) else $error("disable instruction lost");
  return_gie_a: assert property (return_from_irq_instruction && !op_trap |=> global_irq_enable || fetch_redirect)
    else $error("return did not enable");
  hw_vector_a: assert property (fetch_redirect && !$past(op_trap)
    |-> fetch_vector == 12'h008 && $past(global_irq_enable)) else $error("bad hardware take");
  take_clears_a: assert property (fetch_redirect |-> !global_irq_enable)
    else $error("global enable kept on take");
  one_take_a: assert property (fetch_redirect && !op_trap |=> !fetch_redirect)
    else $error("second take");
  wdt_reset_a: assert property (watchdog_reset_req |-> cfg_watchdog_exists && !cfg_watchdog_irq_mode)
    else $error("reset request in wrong mode");
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("access phase not ready");
endmodule
bind irq_and_watchdog_unit irq_unit_sva chk_i (.*);
`default_nettype wire

// *** verification/core_model.sv ***
// Core fetch and decode model issuing instruction strobes
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Redirect from the unit
  input  wire logic        fetch_redirect,
  input  wire logic [11:0] fetch_vector,
  // Instruction strobes
  output logic             op_trap,
  output logic             irq_on_instruction,
  output logic             irq_off_instruction,
  output logic             return_from_irq_instruction,
  output logic             kick_watchdog_instruction
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0]  strobe_r = 5'h00;   // One-hot instruction in execute
  int          last_k   = -1;      // Previous instruction
  int          taken    = 0;       // Redirects seen
  logic [11:0] last_vec = 12'h000; // Vector of last redirect
  assign {kick_watchdog_instruction, return_from_irq_instruction, irq_off_instruction,
          irq_on_instruction, op_trap} = strobe_r;
  // Execute one instruction: 0 trap, 1 on, 2 off, 3 return, 4 kick
  task automatic issue(input int k);
    if (k == 3 && last_k == 1) @(posedge pclk); // Never enable right before return
    strobe_r[k] <= 1'b1;
    @(posedge pclk);
    strobe_r[k] <= 1'b0;
    last_k = k;
    @(posedge pclk);
  endtask
  // Fetch side: follow each redirect
  always @(posedge pclk) begin
    if (!presetn) taken = 0;
    else if (fetch_redirect === 1'b1) begin
      taken++;
      last_vec = fetch_vector;
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Testbench for the interrupt and watchdog unit
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // Stimulus and observed signals
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
  logic [7:0] paddr = 8'h00, porta_in = 8'h00;
  logic [5:0] portb_in = 6'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic op_trap, irq_on_instruction, irq_off_instruction, return_from_irq_instruction;
  logic kick_watchdog_instruction, fetch_redirect, global_irq_enable, watchdog_reset_req;
  logic [11:0] fetch_vector;
  logic cfg_watchdog_exists = 1, cfg_watchdog_irq_mode = 1, low_voltage_out = 1, watchdog_osc = 0;
  logic [1:0] cfg_watchdog_period = 2'h0;
  logic timer0_overflow = 0, timer1_underflow = 0, timer3_underflow = 0;
  logic [13:0] pin_is_input = 14'h3FFF;
  logic [2:0] osc_cnt = 3'h0;
  int mismatches = 0, checks_done = 0, n0, n;
  // Short watchdog periods
  irq_and_watchdog_unit #(.WDT_CNT_0(4), .WDT_CNT_1(5), .WDT_CNT_2(6), .WDT_CNT_3(7)) dut (.*);
  core_model core (.*);
  // Clock and a slow free-running watchdog oscillator
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) begin
    osc_cnt <= (osc_cnt == 3'h4) ? 3'h0 : osc_cnt + 3'h1;
    if (osc_cnt == 3'h4) watchdog_osc <= ~watchdog_osc;
  end
  // ========
  // Verdict and run end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One bus transfer; ev lands a timer0 event on the commit edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic ev);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    timer0_overflow <= ev;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    rerr = pslverr;
    timer0_overflow <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(nm, exp, rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  // Timer event pulses: bit0 timer0, bit1 timer1, bit2 timer3
  task automatic tmr(input logic [2:0] m);
    {timer3_underflow, timer1_underflow, timer0_overflow} <= m;
    @(posedge pclk);
    {timer3_underflow, timer1_underflow, timer0_overflow} <= 3'h0;
    @(posedge pclk);
  endtask
  // Bounded waits on the redirect count and the reset request
  task automatic wait_take(input int prev);
    for (n = 0; n < 10 && core.taken == prev; n++) @(posedge pclk);
    if (core.taken == prev) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic wait_req();
    for (n = 0; n < 300 && watchdog_reset_req !== 1'b1; n++) @(posedge pclk);
    if (n >= 300) begin
      mismatches++;
      complete_run();
    end
  endtask
  // ========
  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h0C, 32'h10, "status");
    rd(8'h08, 32'h80, "power");
    rd(8'h04, 32'h0, "enables");
    rd(8'h40, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, rerr});
    $display("test reset values done");
    tmr(3'h7);
    rd(8'h00, 32'h0, "masked flags");
    wr(8'h04, 32'h07);
    rd(8'h00, 32'h07, "timer flags");
    wr(8'h00, 32'hFD);
    rd(8'h00, 32'h05, "clear one");
    apb(1'b1, 8'h00, 32'hFA, 1'b1);
    rd(8'h00, 32'h01, "event wins");
    $display("test flags done");
    tmr(3'h2);
    n0 = core.taken;
    core.issue(1);
    wait_take(n0);
    chk("hw vector", {20'h0, core.last_vec}, 32'h008);
    rd(8'h20, 32'h4, "hw state");
    chk("one take", 32'(n0 + 1), 32'(core.taken));
    wr(8'h00, 32'h00);
    core.issue(3);
    rd(8'h20, 32'h1, "return gie");
    core.issue(2);
    n0 = core.taken;
    core.issue(0);
    wait_take(n0);
    chk("trap vector", {20'h0, core.last_vec}, 32'h001);
    rd(8'h20, 32'h2, "trap state");
    core.issue(3);
    rd(8'h20, 32'h1, "trap return");
    core.issue(2);
    rd(8'h20, 32'h0, "disabled");
    $display("test core done");
    wr(8'h04, 32'hB8);
    wr(8'h10, 32'hFF);
    porta_in <= 8'h08;
    repeat (8) @(posedge pclk);
    rd(8'h00, 32'h08, "pin change");
    wr(8'h00, 32'h00);
    wr(8'h14, 32'h03);
    wr(8'h18, 32'h07);
    portb_in <= 6'h03;
    pin_is_input <= 14'h3FF7;
    porta_in <= 8'h00;
    repeat (8) @(posedge pclk);
    rd(8'h00, 32'h30, "ext edges");
    low_voltage_out <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(8'h00, 32'hB0, "low volt");
    $display("test pins done");
    wr(8'h04, 32'h40);
    wr(8'h00, 32'h00);
    core.issue(4);
    rd(8'h0C, 32'h10, "kick");
    repeat (80) @(posedge pclk);
    rd(8'h00, 32'h40, "wdt flag");
    rd(8'h0C, 32'h0, "expired");
    wr(8'h08, 32'h00);
    core.issue(4);
    wr(8'h00, 32'h00);
    repeat (80) @(posedge pclk);
    rd(8'h00, 32'h0, "halted");
    cfg_watchdog_irq_mode <= 1'b0;
    cfg_watchdog_period <= 2'h3;
    wr(8'h08, 32'h80);
    wait_req();
    wr(8'h1C, 32'h09);
    core.issue(4);
    wait_req();
    chk("prescaled", 32'h1, {31'h0, n > 100});
    rd(8'h00, 32'h0, "no flag in reset mode");
    cfg_watchdog_exists <= 1'b0;
    core.issue(4);
    repeat (200) @(posedge pclk);
    rd(8'h0C, 32'h10, "no watchdog");
    $display("test watchdog done");
    complete_run();
  end
endmodule
`default_nettype wire
